// ---- acd_pkg.sv ----
// Constants and types shared by the serial configuration decoder, plus the result shifter.
// Assumes one 25 MHz system clock; every serial pin is sampled by that clock.
package acd_pkg;
   // Command byte selector bits
   localparam int BIT_CONV = 7;
   localparam int BIT_SETUP = 6;
   localparam int BIT_AVG = 5;
   localparam int BIT_RESET = 4;
   localparam int BIT_FIFO_ONLY = 3;
   // Setup field positions (inside the six stored bits)
   localparam int SETUP_CLK_HI = 5;
   localparam int SETUP_CLK_LO = 4;
   localparam int SETUP_REF_HI = 3;
   localparam int SETUP_REF_LO = 2;
   localparam int SETUP_PTR_HI = 1;
   localparam int SETUP_PTR_LO = 0;
   // Averaging field positions (inside the five stored bits)
   localparam int AVG_ENABLE = 4;
   localparam int AVG_COUNT_HI = 3;
   localparam int AVG_COUNT_LO = 2;
   localparam int AVG_REPEAT_HI = 1;
   localparam int AVG_REPEAT_LO = 0;
   // Reset values
   localparam logic [5:0] SETUP_DEFAULT = 6'h20;
   localparam logic [7:0] PAIRS_DEFAULT = 8'h00;
   localparam logic [4:0] AVG_DEFAULT = 5'h00;
   // Mode encodings
   localparam logic [1:0] CLK_STROBE_INT = 2'h0;
   localparam logic [1:0] CLK_STROBE_ACQ = 2'h1;
   localparam logic [1:0] CLK_SERIAL_INT = 2'h2;
   localparam logic [1:0] CLK_SERIAL_EXT = 2'h3;
   localparam logic [1:0] REF_INT_AUTO = 2'h0;
   localparam logic [1:0] REF_EXT_SINGLE = 2'h1;
   localparam logic [1:0] REF_INT_ON = 2'h2;
   localparam logic [1:0] REF_EXT_DIFF = 2'h3;
   localparam logic [1:0] SCAN_REPEAT = 2'h2;
   // Result framing
   localparam int RESULT_BITS = 12;
   localparam int FRAME_BITS = 16;
   localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
   // Kelvin to Celsius offset in eighths of a degree
   localparam logic [12:0] TEMP_OFFSET_DEFAULT = 13'h0889;
   // Serial clock limit in conversion clock mode; least period rounds up
   localparam int CLOCK_HZ = 25000000;
   localparam int SCLK_MAX_HZ = 4800000;
   localparam int SCLK_MIN_CYC = (CLOCK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
   localparam logic [3:0] SCLK_MIN_CYC_4 = 4'(SCLK_MIN_CYC);

   // Register selected by a received command byte
   typedef enum logic [2:0] {
      TGT_NONE = 3'b000,
      TGT_CONV = 3'b001,
      TGT_SETUP = 3'b010,
      TGT_AVG = 3'b011,
      TGT_RESET = 3'b100
   } acd_target_type;

   // What the next received byte means
   typedef enum logic {
      RX_COMMAND = 1'b0,
      RX_PAIR_DATA = 1'b1
   } acd_rx_state_type;
endpackage

`timescale 1ns/1ps
// Parallel-load shifter that drives the serial output, MSB first
module acd_out_shifter #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Load side
   input wire logic load,
   input wire logic [WIDTH-1:0] load_word,
   // Shift side
   input wire logic shift,
   output logic serial_bit
);
   logic [WIDTH-1:0] word_r; // Frame being shifted out

   // Load wins over shift so a fresh frame is never skewed by one bit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         word_r <= '0;
      end else if (load) begin
         word_r <= load_word;
      end else if (shift) begin
         word_r <= {word_r[WIDTH-2:0], 1'b0};
      end
   end

   assign serial_bit = word_r[WIDTH-1];
endmodule

// ---- acd_decoder.sv ----
// Serial configuration decoder: receives command bytes and drives the converter's mode lines.
// Assumes the host drives the serial pins asynchronously; all are synchronised here.
//
// How it works
// R1: 01xxxxxx byte loads setup register
// R2: Clock mode high bit is one after power-up
// R3: Clock modes 00/01 start from strobe pin
// R4: Modes 10/11 start on conversion write; pin becomes input
// R5: Mode 01 acquisition follows strobe; others internal
// R6: Mode 11 uses serial clock; host keeps 4.8MHz
// R7: Reference 00 internal, off after scan, wake delay
// R8: Reference 10 internal, always on, no delay
// R9: 01/11 external; only 11 claims negative reference pin
// R10: Pointer 00/01 leaves pair registers untouched
// R11: Pointer 10: next byte into unipolar pairs
// R12: Pointer 11: next byte into bipolar pairs
// R13: Unipolar bit 7 is inputs 0/1, downward
// R14: Bipolar bits map pairs like unipolar
// R15: Results framed as four zeros plus twelve bits
// R16: Sample input on rise, shift output on fall
// R17: Unipolar binary, bipolar two's complement
// R18: 001xxxxx byte loads averaging register
// R19: Averaging off one conversion; else 4/8/16/32
// R20: Repeat scan returns 4/8/12/16 results
// R21: Reset byte: full reset or FIFO clear
// R22: Temperature is high minus low minus offset
// R23: Bit 7 set in a command byte means conversion write
// R24: Pair in both registers counts as unipolar
// R25: Reset leaves zeros except setup clock mode 10
// R26: Clock mode 11 disables averaging
// R27: Decode by top one bit; zero byte ignored
`timescale 1ns/1ps
module acd_decoder
   import acd_pkg::*;
#(
   parameter logic [12:0] TEMP_OFFSET = TEMP_OFFSET_DEFAULT
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Serial port pins
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_enable,
   // Convert strobe pin
   input wire logic convert_strobe_pin,
   // Conversion control
   output logic conversion_start,
   output logic [3:0] conversion_channel,
   output logic [1:0] scan_mode,
   output logic temperature_request,
   output logic top_analog_input_select,
   output logic acquire_external,
   output logic acquisition_internal,
   output logic conversion_clock_external,
   output logic sclk_rate_fault,
   // Reference control
   output logic reference_internal,
   output logic reference_always_on,
   output logic reference_wake_delay,
   output logic negative_reference_select,
   // Input pair configuration
   output logic [7:0] pair_unipolar,
   output logic [7:0] pair_bipolar,
   // Averaging and repeat counts
   output logic [5:0] averaging_count,
   output logic [4:0] repeat_results,
   // FIFO control
   output logic fifo_clear,
   // Result input from the converter core
   input wire logic result_load,
   input wire logic [11:0] result_code,
   input wire logic result_bipolar,
   input wire logic temperature_load,
   input wire logic [11:0] temp_high_code,
   input wire logic [11:0] temp_low_code
);

   // Pick the target register from the highest one bit
   function automatic acd_target_type decode_target(input logic [7:0] b);
      if (b[BIT_CONV]) begin
         return TGT_CONV; // [R23]
      end else if (b[BIT_SETUP]) begin
         return TGT_SETUP;
      end else if (b[BIT_AVG]) begin
         return TGT_AVG;
      end else if (b[BIT_RESET]) begin
         return TGT_RESET;
      end else begin
         return TGT_NONE; // [R27]
      end
   endfunction

   // Conversions per result; mode 11 forbids averaging
   function automatic logic [5:0] avg_count(input logic [4:0] cfg, input logic [1:0] mode);
      if (!cfg[AVG_ENABLE] || mode == CLK_SERIAL_EXT) begin
         return 6'h01; // [R19] [R26]
      end else begin
         case ({cfg[AVG_COUNT_HI], cfg[AVG_COUNT_LO]})
            2'h0: return 6'h04;
            2'h1: return 6'h08;
            2'h2: return 6'h10;
            default: return 6'h20;
         endcase
      end
   endfunction

   // Results returned for a single-channel scan
   function automatic logic [4:0] rep_count(input logic [4:0] cfg, input logic [1:0] scan);
      if (scan != SCAN_REPEAT) begin
         return 5'h01;
      end else begin
         case ({cfg[AVG_REPEAT_HI], cfg[AVG_REPEAT_LO]})
            2'h0: return 5'h04; // [R20]
            2'h1: return 5'h08;
            2'h2: return 5'h0C;
            default: return 5'h10;
         endcase
      end
   endfunction

   // Pin synchronisers: bit 0 select, 1 clock, 2 data, 3 strobe
   logic [3:0] sync1_r; // First stage, read only by the second
   logic [3:0] sync2_r; // Safe copies of the pins
   logic sclk_prev_r; // Last serial clock level, for edges
   logic strobe_prev_r; // Last strobe level, for edges

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 4'h9;
         sync2_r <= 4'h9;
         sclk_prev_r <= 1'b0;
         strobe_prev_r <= 1'b1;
      end else begin
         sync1_r <= {convert_strobe_pin, serial_in, serial_clock, chip_select_n};
         sync2_r <= sync1_r;
         sclk_prev_r <= sync2_r[1];
         strobe_prev_r <= sync2_r[3];
      end
   end

   logic selected; // Chip select active
   logic sclk_rise; // Rising serial clock edge seen
   logic sclk_fall; // Falling serial clock edge seen
   logic strobe_rise; // Strobe released
   assign selected = !sync2_r[0];
   assign sclk_rise = selected && sync2_r[1] && !sclk_prev_r;
   assign sclk_fall = selected && !sync2_r[1] && sclk_prev_r;
   assign strobe_rise = sync2_r[3] && !strobe_prev_r;

   // Byte assembly; a deselect drops any partial byte
   logic [2:0] bit_cnt_r; // Bits received in this byte
   logic [6:0] shift_in_r; // Bits received so far
   logic byte_done; // Eighth bit arrives this cycle
   logic [7:0] rx_byte; // Completed byte, valid with byte_done
   assign byte_done = sclk_rise && bit_cnt_r == 3'h7;
   assign rx_byte = {shift_in_r, sync2_r[2]};

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_r <= 3'h0;
         shift_in_r <= 7'h00;
      end else if (!selected) begin
         bit_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'h1; // [R16]
         shift_in_r <= rx_byte[6:0];
      end
   end

   acd_target_type target; // Register the byte addresses
   assign target = decode_target(rx_byte);

   // Byte interpretation state and configuration registers
   acd_rx_state_type rx_state_r; // Command or pair data expected
   logic pair_is_bipolar_r; // Which pair register takes the data byte
   logic [5:0] setup_r; // Clock, reference and pointer fields
   logic [7:0] unipolar_r; // Unipolar pair enables
   logic [7:0] bipolar_r; // Bipolar pair enables
   logic [4:0] avg_cfg_r; // Averaging and repeat fields
   logic conv_write_r; // Conversion byte just arrived
   logic fifo_clear_r; // FIFO clear pulse

   // The pending pair byte is abandoned when select rises, a host that breaks the
   // 16-clock frame does not then corrupt the next command.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_state_r <= RX_COMMAND;
         pair_is_bipolar_r <= 1'b0;
         setup_r <= SETUP_DEFAULT; // [R2] [R25]
         unipolar_r <= PAIRS_DEFAULT;
         bipolar_r <= PAIRS_DEFAULT;
         avg_cfg_r <= AVG_DEFAULT;
         conversion_channel <= 4'h0;
         scan_mode <= 2'h0;
         temperature_request <= 1'b0;
         conv_write_r <= 1'b0;
         fifo_clear_r <= 1'b0;
      end else begin
         conv_write_r <= 1'b0;
         fifo_clear_r <= 1'b0;
         if (!selected) begin
            rx_state_r <= RX_COMMAND;
         end else if (byte_done) begin
            case (rx_state_r)
               RX_PAIR_DATA: begin
                  rx_state_r <= RX_COMMAND;
                  if (pair_is_bipolar_r) begin
                     bipolar_r <= rx_byte; // [R12] [R14]
                  end else begin
                     unipolar_r <= rx_byte; // [R11] [R13]
                  end
               end
               RX_COMMAND: begin
                  case (target)
                     TGT_CONV: begin
                        conversion_channel <= rx_byte[6:3]; // [R23]
                        scan_mode <= rx_byte[2:1];
                        temperature_request <= rx_byte[0];
                        conv_write_r <= 1'b1;
                     end
                     TGT_SETUP: begin
                        setup_r <= rx_byte[5:0]; // [R1]
                        // Pointer 1x expects a data byte, 0x none
                        if (rx_byte[SETUP_PTR_HI]) begin
                           rx_state_r <= RX_PAIR_DATA; // [R11] [R12]
                           pair_is_bipolar_r <= rx_byte[SETUP_PTR_LO];
                        end // [R10]
                     end
                     TGT_AVG: begin
                        avg_cfg_r <= rx_byte[4:0]; // [R18]
                     end
                     TGT_RESET: begin
                        if (rx_byte[BIT_FIFO_ONLY]) begin
                           fifo_clear_r <= 1'b1; // [R21]
                        end else begin
                           setup_r <= SETUP_DEFAULT; // [R21] [R25]
                           unipolar_r <= PAIRS_DEFAULT;
                           bipolar_r <= PAIRS_DEFAULT;
                           avg_cfg_r <= AVG_DEFAULT;
                           conversion_channel <= 4'h0;
                           scan_mode <= 2'h0;
                           temperature_request <= 1'b0;
                           fifo_clear_r <= 1'b1;
                        end
                     end
                     default: begin
                        // Byte with bits 7 to 4 all zero selects nothing
                     end // [R27]
                  endcase
               end
               default: begin
                  rx_state_r <= RX_COMMAND;
               end
            endcase
         end
      end
   end

   logic [1:0] clock_mode; // Stored clock mode field
   logic [1:0] ref_mode; // Stored reference mode field
   assign clock_mode = {setup_r[SETUP_CLK_HI], setup_r[SETUP_CLK_LO]};
   assign ref_mode = {setup_r[SETUP_REF_HI], setup_r[SETUP_REF_LO]};

   // Conversion start: strobe release in modes 0x, conversion write in modes 1x
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         conversion_start <= 1'b0;
         acquire_external <= 1'b0;
      end else begin
         if (clock_mode[1]) begin
            conversion_start <= conv_write_r; // [R4]
         end else begin
            conversion_start <= strobe_rise; // [R3]
         end
         // Mode 01: acquisition lasts while the strobe is held low
         acquire_external <= clock_mode == CLK_STROBE_ACQ && !sync2_r[3]; // [R5]
      end
   end

   // Mode and configuration lines, all from flip-flops
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         top_analog_input_select <= 1'b0;
         acquisition_internal <= 1'b0;
         conversion_clock_external <= 1'b0;
         reference_internal <= 1'b0;
         reference_always_on <= 1'b0;
         reference_wake_delay <= 1'b0;
         negative_reference_select <= 1'b0;
         pair_unipolar <= 8'h00;
         pair_bipolar <= 8'h00;
         averaging_count <= 6'h01;
         repeat_results <= 5'h01;
         fifo_clear <= 1'b0;
         serial_out_enable <= 1'b0;
      end else begin
         top_analog_input_select <= clock_mode[1]; // [R4]
         acquisition_internal <= clock_mode != CLK_STROBE_ACQ; // [R5]
         conversion_clock_external <= clock_mode == CLK_SERIAL_EXT; // [R6]
         reference_internal <= ref_mode == REF_INT_AUTO || ref_mode == REF_INT_ON; // [R7] [R8]
         reference_always_on <= ref_mode == REF_INT_ON; // [R8]
         reference_wake_delay <= ref_mode == REF_INT_AUTO; // [R7] [R9]
         negative_reference_select <= ref_mode == REF_EXT_DIFF; // [R9]
         pair_unipolar <= unipolar_r; // [R13]
         pair_bipolar <= bipolar_r & ~unipolar_r; // [R24]
         averaging_count <= avg_count(avg_cfg_r, clock_mode); // [R19] [R26]
         repeat_results <= rep_count(avg_cfg_r, scan_mode); // [R20]
         fifo_clear <= fifo_clear_r;
         serial_out_enable <= selected;
      end
   end

   // Serial clock rate watch in mode 11; the converter would lose accuracy above
   // the limit, so the fault holds until the host deselects.
   logic [3:0] sclk_gap_r; // Cycles since the last rising edge, saturating
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sclk_gap_r <= 4'hF;
         sclk_rate_fault <= 1'b0;
      end else begin
         if (sclk_rise) begin
            sclk_gap_r <= 4'h1;
         end else if (sclk_gap_r != 4'hF) begin
            sclk_gap_r <= sclk_gap_r + 4'h1;
         end
         if (!selected) begin
            sclk_rate_fault <= 1'b0;
         end else if (sclk_rise && clock_mode == CLK_SERIAL_EXT && sclk_gap_r < SCLK_MIN_CYC_4) begin
            sclk_rate_fault <= 1'b1; // [R6]
         end
      end
   end

   // Result framing: temperature arithmetic, bipolar coding, four leading zeros
   logic [12:0] temp_diff; // High-bias minus low-bias minus offset
   logic [11:0] result_word; // Twelve result bits before framing
   assign temp_diff = {1'b0, temp_high_code} - {1'b0, temp_low_code} - TEMP_OFFSET; // [R22]
   always_comb begin
      if (temperature_load) begin
         result_word = temp_diff[11:0]; // [R22]
      end else if (result_bipolar) begin
         result_word = result_code ^ BIPOLAR_FLIP; // [R17]
      end else begin
         result_word = result_code; // [R17]
      end
   end

   acd_out_shifter #(
      .WIDTH(FRAME_BITS)
   ) u_out_shifter (
      .clock(clock),
      .resetn(resetn),
      .load(result_load || temperature_load),
      .load_word({4'h0, result_word}), // [R15]
      .shift(sclk_fall), // [R16]
      .serial_bit(serial_out)
   );

   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_cmd_byte;
      byte_done && selected && rx_state_r == RX_COMMAND;
   endsequence
   sequence s_setup_byte;
      s_cmd_byte ##0 rx_byte[7:6] == 2'b01;
   endsequence

   a_setup_load: assert property (s_setup_byte |=> setup_r == $past(rx_byte[5:0])) // [R1]
      else $error("setup byte not loaded");
   a_ptr_none: assert property (s_setup_byte ##0 !rx_byte[1]
      |=> rx_state_r == RX_COMMAND && $stable(unipolar_r) && $stable(bipolar_r)) // [R10]
      else $error("pointer 0x changed pair registers");
   // The data byte needs eight more serial clocks, so wait for it in pair state
   a_pair_data: assert property (s_setup_byte ##0 rx_byte[1]
      ##[1:300] (byte_done && selected && rx_state_r == RX_PAIR_DATA)
      |=> (pair_is_bipolar_r ? bipolar_r : unipolar_r) == $past(rx_byte)) // [R11] [R12]
      else $error("pair byte not stored");
   a_conv_priority: assert property (s_cmd_byte ##0 rx_byte[7]
      |=> $stable(setup_r) && conv_write_r && conversion_channel == $past(rx_byte[6:3])) // [R23]
      else $error("conversion byte misdecoded");
   a_avg_load: assert property (s_cmd_byte ##0 rx_byte[7:5] == 3'b001
      |=> avg_cfg_r == $past(rx_byte[4:0])) // [R18]
      else $error("averaging byte not loaded");
   a_full_reset: assert property (s_cmd_byte ##0 rx_byte[7:3] == 5'b00010
      |=> setup_r == SETUP_DEFAULT && unipolar_r == 8'h00 && avg_cfg_r == 5'h00
      ##1 fifo_clear) // [R21] [R25]
      else $error("full reset incomplete");
   a_fifo_only: assert property (s_cmd_byte ##0 rx_byte[7:3] == 5'b00011
      |=> $stable(setup_r) && $stable(avg_cfg_r) ##1 fifo_clear) // [R21]
      else $error("FIFO clear touched registers");
   a_zero_ignored: assert property (s_cmd_byte ##0 rx_byte == 8'h00
      |=> $stable(setup_r) && $stable(avg_cfg_r) && !conv_write_r && !fifo_clear_r) // [R27]
      else $error("zero byte changed state");
   a_avg_disabled: assert property (clock_mode == CLK_SERIAL_EXT ##1 clock_mode == CLK_SERIAL_EXT
      |-> averaging_count == 6'h01) // [R26]
      else $error("averaging active in mode 11");
   a_unipolar_wins: assert property ((pair_unipolar & pair_bipolar) == 8'h00) // [R24]
      else $error("pair both unipolar and bipolar");
   a_start_source: assert property (conversion_start
      |-> $past(clock_mode[1]) ? $past(conv_write_r) : $past(strobe_rise)) // [R3] [R4]
      else $error("conversion started from wrong source");
endmodule

// ---- acd_host.sv ----
// Host controller model for the four-wire serial port of the decoder.
// Assumes the bench calls xfer; the serial clock idles low between frames.
`timescale 1ns/1ps
module acd_host (
   // Serial port pins
   output logic chip_select_n,
   output logic serial_clock,
   output logic serial_in,
   input wire logic serial_out
);
   logic [15:0] rx; // Bits taken from the output line

   // Idle pins at time zero
   initial begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_in = 1'b0;
   end

   // One frame of n bits, 320 ns period keeps below the mode 11 limit
   task automatic xfer(input logic [15:0] tx, input int n);
      #13 chip_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = tx[i]; // Set during low phase, stable at rise
         #160 serial_clock = 1'b1;
         rx = {rx[14:0], serial_out}; // Output taken at rise
         #160 serial_clock = 1'b0;
      end
      #160 chip_select_n = 1'b1;
      serial_in = ~serial_in; // Released line shows no stale value
      // Keep select high long enough for the decoder to see the frame end
      #160;
   endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the serial configuration decoder.
// Assumes the host model drives the serial pins; core result inputs are driven here.
`timescale 1ns/1ps
module testbench;
   import acd_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic strobe = 1'b1; // Strobe pin idles high
   logic rload = 1'b0, rbip = 1'b0, tload = 1'b0;
   logic [11:0] rcode = 12'h000, th = 12'h000, tl = 12'h000;
   logic cs_n, sclk, sin, sout;
   logic tai, acqi, cext;
   logic ri, ron, rwake, rneg;
   logic [7:0] uni, bip, u, b;
   logic [5:0] avg;
   logic [4:0] rep;
   logic [3:0] chn;
   logic [11:0] e;
   logic fclr, cstart, treq;
   logic [1:0] smode;
   int fifo_seen = 0; // FIFO clear pulses seen
   int starts = 0; // Conversion start pulses seen
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed_v;

   // 25 MHz clock
   initial begin
      forever #20 clock = ~clock;
   end

   acd_host host (.chip_select_n(cs_n), .serial_clock(sclk), .serial_in(sin),
      .serial_out(sout));

   acd_decoder u_dut (.clock(clock), .resetn(resetn), .chip_select_n(cs_n),
      .serial_clock(sclk), .serial_in(sin), .serial_out(sout), .serial_out_enable(),
      .convert_strobe_pin(strobe), .conversion_start(cstart), .conversion_channel(chn),
      .scan_mode(smode), .temperature_request(treq), .top_analog_input_select(tai),
      .acquire_external(), .acquisition_internal(acqi), .conversion_clock_external(cext),
      .sclk_rate_fault(), .reference_internal(ri), .reference_always_on(ron),
      .reference_wake_delay(rwake), .negative_reference_select(rneg), .pair_unipolar(uni),
      .pair_bipolar(bip), .averaging_count(avg), .repeat_results(rep), .fifo_clear(fclr),
      .result_load(rload), .result_code(rcode), .result_bipolar(rbip),
      .temperature_load(tload), .temp_high_code(th), .temp_low_code(tl));

   // Expected reference lines: internal, always on, wake delay, negative pin
   function automatic logic [3:0] ref_exp(input logic [1:0] r);
      return {~r[0], r == 2'h2, r == 2'h0, r == 2'h3};
   endfunction

   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Let decode and output flops land
   task automatic settle();
      repeat (3) @(posedge clock);
      #4;
   endtask

   // Verdict
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Count one-cycle pulses so that none is missed between settles
   always @(posedge clock) begin
      if (fclr === 1'b1) begin
         fifo_seen++;
      end
      if (cstart === 1'b1) begin
         starts++;
      end
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         close_out();
      end
   end

   // Main sequence
   initial begin
      seed_v = $urandom(32'h1696);
      repeat (16) @(posedge clock);
      #4 resetn = 1'b1;
      settle();
      check("power-up strobe use", tai, 1);
      check("power-up averaging", avg, 1);
      check("power-up pairs", {uni, bip}, 0);
      // Every clock and reference mode, pointer 00 or 01
      for (int m = 0; m < 16; m++) begin
         host.xfer({8'h00, 2'b01, 4'(m), 2'($urandom_range(1))}, 8);
         settle();
         check("strobe use", tai, m[3]);
         check("internal acquisition", acqi, m[3:2] != 2'h1);
         check("external clock", cext, m[3:2] == 2'h3);
         check("reference", {ri, ron, rwake, rneg}, ref_exp(m[1:0]));
         check("pairs kept", {uni, bip}, 0);
      end
      // Pair registers through both pointers, overlap resolved to unipolar
      u = 8'($urandom);
      b = 8'($urandom) | u;
      host.xfer({8'h62, u}, 16);
      host.xfer({8'h63, b}, 16);
      settle();
      check("unipolar pairs", uni, u);
      check("bipolar pairs", bip, b & ~u);
      // Every averaging setting, each followed by a repeated scan
      for (int a = 0; a < 32; a++) begin
         e[3:0] = 4'($urandom);
         host.xfer({3'b001, 5'(a), 1'b1, e[3:0], 3'b100}, 16);
         settle();
         check("averaging", avg, a[4] ? 6'(4 << a[3:2]) : 6'h01);
         check("repeat count", rep, 5'((a[1:0] + 1) * 4));
         check("channel", chn, e[3:0]);
         check("scan and temp", {smode, treq}, 3'b100);
      end
      check("write starts", starts, 32);
      // Serial conversion clock overrides averaging
      host.xfer(16'h7030, 16);
      settle();
      check("averaging off", avg, 1);
      // Zero byte and FIFO-only reset keep registers; full reset restores
      host.xfer({8'h00, 8'h18 | 8'($urandom_range(7))}, 16);
      settle();
      check("kept pairs", uni, u);
      host.xfer(16'h0010 | 16'($urandom_range(7)), 8);
      settle();
      check("reset pairs", {uni, bip}, 0);
      check("reset clock mode", tai, 1);
      check("fifo clears", fifo_seen, 2);
      // Result and temperature frames on the output line
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         #4 rcode = 12'($urandom);
         rbip = k[0];
         th = 12'($urandom_range(4095, 2400));
         tl = 12'($urandom_range(200));
         rload = ~k[1];
         tload = k[1];
         e = k[1] ? 12'(th - tl - TEMP_OFFSET_DEFAULT) : rcode ^ (k[0] ? 12'h800 : 12'h000);
         @(posedge clock);
         #4 rload = 1'b0;
         tload = 1'b0;
         host.xfer(16'h0000, 16);
         check("result frame", host.rx, {4'h0, e});
      end
      close_out();
   end
endmodule
